// ==== superio_watchdog_gpio.sv ====
`timescale 1ns/1ps
`include "wdt_gpio_map.svh"

module superio_watchdog_gpio #(
	parameter int TICK_CYCLES   = `SECOND_NS / `CLK_PERIOD_NS,
	parameter int PULSE_CYCLES  = `RESET_PULSE_CYCLES
) (
	input  wire logic                   sys_clk,
	input  wire logic                   srst,
	input  wire wdt_gpio_pkg::io_req_t  io_req,
	output logic [7:0]                  io_rdata,
	input  wire logic [7:0]             general_io_port_five_in,
	output logic [7:0]                  general_io_port_five_out,
	output logic [7:0]                  general_io_port_five_oe,
	output logic                        system_reset_out
);

	wdt_gpio_pkg::cfg_state_t cfg_state;
	logic [7:0]  index;
	logic [7:0]  ldn;
	logic [7:0]  activate;
	logic [7:0]  port_dir;
	logic [7:0]  port_data;
	logic [7:0]  unit_sel;
	logic [7:0]  count;
	logic [7:0]  pin_meta;
	logic [7:0]  pin_sync;
	logic [31:0] prescale;
	logic [5:0]  sec_in_min;
	logic [7:0]  pulse_left;
	logic        sec_tick;
	logic        unit_tick;
	logic        idx_wr;
	logic        reg_wr;
	logic        dev_wr;
	logic        count_wr;
	logic        wdt_on;
	logic        expire;
	logic [7:0]  next_rdata;

	// Decode of host writes; device registers only answer when this device is selected.
	assign idx_wr   = io_req.wr && !io_req.is_data;
	assign reg_wr   = io_req.wr && io_req.is_data && (cfg_state == wdt_gpio_pkg::CFG_OPEN);
	assign dev_wr   = reg_wr && (ldn == `LDN_THIS_DEVICE);
	assign count_wr = dev_wr && (index == `IDX_TIMEOUT_COUNT);
	assign wdt_on   = activate[`ACT_WATCHDOG_BIT];

	// Lock sequence: two unlock keys in a row open the registers, the lock key closes them.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg_state <= wdt_gpio_pkg::CFG_LOCKED;
		end else if (idx_wr) begin
			unique case (cfg_state)
				wdt_gpio_pkg::CFG_LOCKED: begin
					if (io_req.wdata == `CFG_UNLOCK_KEY) cfg_state <= wdt_gpio_pkg::CFG_HALF_KEY;
				end
				wdt_gpio_pkg::CFG_HALF_KEY: begin
					cfg_state <= (io_req.wdata == `CFG_UNLOCK_KEY) ? wdt_gpio_pkg::CFG_OPEN
					                                              : wdt_gpio_pkg::CFG_LOCKED;
				end
				wdt_gpio_pkg::CFG_OPEN: begin
					if (io_req.wdata == `CFG_LOCK_KEY) cfg_state <= wdt_gpio_pkg::CFG_LOCKED;
				end
				default: cfg_state <= wdt_gpio_pkg::CFG_LOCKED;
			endcase
		end
	end

	// Index register; while locked the index port only watches for keys.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			index <= `RST_INDEX;
		end else if (idx_wr && cfg_state == wdt_gpio_pkg::CFG_OPEN) begin
			index <= io_req.wdata;
		end
	end

	// Logical device select is global and reachable whichever device is chosen.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ldn <= `RST_LDN;
		end else if (reg_wr && index == `IDX_LDN_SELECT) begin
			ldn <= io_req.wdata;
		end
	end

	// Device configuration registers.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			activate  <= `RST_ACTIVATE;
			port_dir  <= `RST_PORT_DIR;
			port_data <= `RST_PORT_DATA;
			unit_sel  <= `RST_UNIT;
		end else if (dev_wr) begin
			if (index == `IDX_ACTIVATE)    activate  <= io_req.wdata;
			if (index == `IDX_PORT_DIR)    port_dir  <= io_req.wdata;
			if (index == `IDX_PORT_DATA)   port_data <= io_req.wdata;
			if (index == `IDX_UNIT_SELECT) unit_sel  <= io_req.wdata;
		end
	end

	// Pins come from outside the clock domain, so they pass two flip-flops.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end else begin
			pin_meta <= general_io_port_five_in;
			pin_sync <= pin_meta;
		end
	end

	// A set direction bit releases the pin; a clear one drives the data bit.
	assign general_io_port_five_oe  = ~port_dir;
	assign general_io_port_five_out = port_data;

	// Read data: input bits show the pins, output bits show the written value.
	always_comb begin
		next_rdata = 8'h00;
		if (!io_req.is_data) begin
			next_rdata = index;
		end else if (cfg_state == wdt_gpio_pkg::CFG_OPEN) begin
			if (index == `IDX_LDN_SELECT) begin
				next_rdata = ldn;
			end else if (ldn == `LDN_THIS_DEVICE) begin
				unique case (index)
					`IDX_ACTIVATE:      next_rdata = activate;
					`IDX_PORT_DIR:      next_rdata = port_dir;
					`IDX_PORT_DATA:     next_rdata = (port_dir & pin_sync) | (~port_dir & port_data);
					`IDX_UNIT_SELECT:   next_rdata = unit_sel;
					`IDX_TIMEOUT_COUNT: next_rdata = count;
					default:            next_rdata = 8'h00;
				endcase
			end
		end
	end

	// Read answers are registered and stand until the next read.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			io_rdata <= 8'h00;
		end else if (io_req.rd) begin
			io_rdata <= next_rdata;
		end
	end

	// Second prescaler; a count write restarts it so the first unit is a full one.
	always_ff @(posedge sys_clk) begin
		if (srst || count_wr) begin
			prescale <= 32'h0000_0000;
		end else if (prescale == 32'(TICK_CYCLES - 1)) begin
			prescale <= 32'h0000_0000;
		end else begin
			prescale <= prescale + 32'h0000_0001;
		end
	end
	assign sec_tick = (prescale == 32'(TICK_CYCLES - 1));

	// Minute divider built from second ticks.
	always_ff @(posedge sys_clk) begin
		if (srst || count_wr) begin
			sec_in_min <= 6'h00;
		end else if (sec_tick) begin
			sec_in_min <= (sec_in_min == 6'(`SECONDS_PER_MINUTE - 1)) ? 6'h00 : sec_in_min + 6'h01;
		end
	end

	// Unit tick follows the minute bit of the unit register.
	assign unit_tick = unit_sel[`UNIT_MINUTE_BIT]
	                 ? (sec_tick && sec_in_min == 6'(`SECONDS_PER_MINUTE - 1))
	                 : sec_tick;
	assign expire = wdt_on && (count == 8'h01) && unit_tick && !count_wr;

	// Countdown. A host write always wins over a decrement in the same cycle.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			count <= `RST_COUNT;
		end else if (count_wr) begin
			count <= io_req.wdata;
		end else if (wdt_on && count != 8'h00 && unit_tick) begin
			count <= count - 8'h01;
		end
	end

	// Reset pulse of fixed length; a zero count never fires, it means stopped.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pulse_left <= 8'h00;
		end else if (expire) begin
			pulse_left <= 8'(PULSE_CYCLES);
		end else if (pulse_left != 8'h00) begin
			pulse_left <= pulse_left - 8'h01;
		end
	end
	assign system_reset_out = (pulse_left != 8'h00);

	// Checks on the behaviour of the block.
	a_reset_on_expiry: assert property (@(posedge sys_clk) disable iff (srst)
		expire |=> system_reset_out [*2])
		else $error("Watchdog expiry did not raise system reset.");

	a_reset_has_cause: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(system_reset_out) |-> $past(wdt_on) && $past(count) == 8'h01)
		else $error("System reset rose without an expiring watchdog.");

	a_second_unit: assert property (@(posedge sys_clk) disable iff (srst)
		(unit_sel == 8'h00 && wdt_on && count != 8'h00 && sec_tick && !count_wr)
		|=> count == $past(count) - 8'h01)
		else $error("Second unit did not decrement the count.");

	a_minute_unit: assert property (@(posedge sys_clk) disable iff (srst)
		(unit_sel == 8'h08 && unit_tick) |-> sec_in_min == 6'h3b)
		else $error("Minute unit ticked before sixty seconds.");

	a_count_load: assert property (@(posedge sys_clk) disable iff (srst)
		count_wr |=> count == $past(io_req.wdata))
		else $error("Count write did not load the countdown.");

	a_count_restart: assert property (@(posedge sys_clk) disable iff (srst)
		(count_wr && wdt_on && io_req.wdata > 8'h01) |=> !expire [*2])
		else $error("Restarted watchdog expired at once.");

	a_stop_no_reset: assert property (@(posedge sys_clk) disable iff (srst)
		(!wdt_on && !system_reset_out) |=> !system_reset_out)
		else $error("Inactive watchdog raised a reset.");

	a_dir_sets_oe: assert property (@(posedge sys_clk) disable iff (srst)
		(dev_wr && index == `IDX_PORT_DIR) |=> general_io_port_five_oe == ~$past(io_req.wdata))
		else $error("Direction write did not set pin drive.");

	a_data_drives: assert property (@(posedge sys_clk) disable iff (srst)
		(dev_wr && index == `IDX_PORT_DATA) |=> general_io_port_five_out == $past(io_req.wdata))
		else $error("Data write did not reach the pins.");

	a_input_read: assert property (@(posedge sys_clk) disable iff (srst)
		(io_req.rd && io_req.is_data && cfg_state == wdt_gpio_pkg::CFG_OPEN
		 && ldn == `LDN_THIS_DEVICE && index == `IDX_PORT_DATA && port_dir == 8'hff)
		|=> io_rdata == $past(pin_sync))
		else $error("Input read did not return pin levels.");

	a_locked_ignore: assert property (@(posedge sys_clk) disable iff (srst)
		(cfg_state == wdt_gpio_pkg::CFG_LOCKED) |=> $stable(port_dir) && $stable(activate))
		else $error("Locked configuration accepted a write.");

	a_activate_on: assert property (@(posedge sys_clk) disable iff (srst)
		(dev_wr && index == `IDX_ACTIVATE && io_req.wdata == 8'h01) |=> wdt_on)
		else $error("Activation write did not start the watchdog.");

	c_expiry: cover property (@(posedge sys_clk) disable iff (srst) expire);
	c_unlock: cover property (@(posedge sys_clk) disable iff (srst)
		cfg_state == wdt_gpio_pkg::CFG_HALF_KEY ##1 cfg_state == wdt_gpio_pkg::CFG_OPEN);
	c_input_read: cover property (@(posedge sys_clk) disable iff (srst)
		io_req.rd && index == `IDX_PORT_DATA && port_dir == 8'hff);
	c_stop: cover property (@(posedge sys_clk) disable iff (srst) $fell(wdt_on) && count != 8'h00);

endmodule // superio_watchdog_gpio

// ==== wdt_gpio_map.svh ====
`ifndef WDT_GPIO_MAP_SVH
`define WDT_GPIO_MAP_SVH

// Configuration index values, as written to the index port.
`define IDX_LDN_SELECT      8'h07
`define IDX_ACTIVATE        8'h30
`define IDX_PORT_DIR        8'he0
`define IDX_PORT_DATA       8'he1
`define IDX_UNIT_SELECT     8'hf5
`define IDX_TIMEOUT_COUNT   8'hf6

// Keys and the logical device that holds this block.
`define CFG_UNLOCK_KEY      8'h87
`define CFG_LOCK_KEY        8'haa
`define LDN_THIS_DEVICE     8'h08

// Field positions.
`define ACT_WATCHDOG_BIT    0
`define UNIT_MINUTE_BIT     3

// Reset values.
`define RST_INDEX           8'h00
`define RST_LDN             8'h00
`define RST_ACTIVATE        8'h00
`define RST_PORT_DIR        8'hff
`define RST_PORT_DATA       8'h00
`define RST_UNIT            8'h00
`define RST_COUNT           8'h00

// Timing: one count unit is a second or a minute of the 200 MHz clock.
`define CLK_PERIOD_NS       5
`define SECOND_NS           1000000000
`define SECONDS_PER_MINUTE  60
`define RESET_PULSE_CYCLES  16

`endif

// ==== wdt_gpio_pkg.sv ====
package wdt_gpio_pkg;

	// One access from the host to the index or data port.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       is_data;
		logic [7:0] wdata;
	} io_req_t;

	// Configuration lock sequence.
	typedef enum logic [1:0] {
		CFG_LOCKED   = 2'b00,
		CFG_HALF_KEY = 2'b01,
		CFG_OPEN     = 2'b10
	} cfg_state_t;

endpackage

// ==== host_model.sv ====
`timescale 1ns/1ps
`include "wdt_gpio_map.svh"

// Host side of the index and data port pair; each access is a one-cycle strobe.
module host_model (
	input  wire logic             sys_clk,
	input  wire logic [7:0]       io_rdata,
	output wdt_gpio_pkg::io_req_t io_req
);
	// The idle bus starts with no strobe and a zero byte; writes turn the byte over so stale data never looks valid.
	initial begin
		io_req = '0;
	end

	// One write strobe, released at the edge that takes it.
	task automatic io_wr(input logic d, input logic [7:0] v);
		@(posedge sys_clk);
		io_req <= '{wr: 1'b1, rd: 1'b0, is_data: d, wdata: v};
		@(posedge sys_clk);
		io_req <= '{wr: 1'b0, rd: 1'b0, is_data: d, wdata: ~v};
	endtask

	// One read strobe; the answer is sampled a cycle and a half after the edge that takes it, since it holds until the next read.
	task automatic io_rd(input logic d, output logic [7:0] v);
		@(posedge sys_clk);
		io_req <= '{wr: 1'b0, rd: 1'b1, is_data: d, wdata: 8'h00};
		@(posedge sys_clk);
		io_req <= '{wr: 1'b0, rd: 1'b0, is_data: d, wdata: 8'h5a};
		@(posedge sys_clk);
		@(negedge sys_clk);
		v = io_rdata;
	endtask

	// A register is reached by its index, then the data port.
	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] v);
		io_wr(1'b0, idx);
		io_wr(1'b1, v);
	endtask

	task automatic reg_rd(input logic [7:0] idx, output logic [7:0] v);
		io_wr(1'b0, idx);
		io_rd(1'b1, v);
	endtask

	// Two keys open the space, then logical device eight is chosen.
	task automatic open_device();
		io_wr(1'b0, `CFG_UNLOCK_KEY);
		io_wr(1'b0, `CFG_UNLOCK_KEY);
		reg_wr(`IDX_LDN_SELECT, `LDN_THIS_DEVICE);
	endtask
endmodule // host_model

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "wdt_gpio_map.svh"

module testbench;
	localparam int TICK  = 10;
	localparam int PULSE = 4;
	logic                  sys_clk;
	logic                  srst;
	wdt_gpio_pkg::io_req_t io_req;
	logic [7:0]            io_rdata;
	logic [7:0]            pin_ext;
	logic [7:0]            pin_out;
	logic [7:0]            pin_oe;
	wire logic [7:0]       pin_level;
	logic                  system_reset_out;
	int                    err_total;
	int                    checks_done;
	logic [7:0]            rv;
	int                    n;

	// A pin follows the device where it drives and the outside level elsewhere.
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & pin_ext);

	superio_watchdog_gpio #(.TICK_CYCLES(TICK), .PULSE_CYCLES(PULSE)) DUT (
		.sys_clk                  (sys_clk),
		.srst                     (srst),
		.io_req                   (io_req),
		.io_rdata                 (io_rdata),
		.general_io_port_five_in  (pin_level),
		.general_io_port_five_out (pin_out),
		.general_io_port_five_oe  (pin_oe),
		.system_reset_out         (system_reset_out)
	);

	host_model host (.sys_clk(sys_clk), .io_rdata(io_rdata), .io_req(io_req));

	// Clock of 5 ns period.
	always #2.5 sys_clk = ~sys_clk;

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Counts cycles until the reset output rises, giving up at the limit.
	task automatic time_fire(input int limit, output int cyc);
		cyc = 0;
		while (system_reset_out !== 1'b1 && cyc < limit) begin
			@(negedge sys_clk);
			cyc++;
		end
	endtask

	// The reset must rise close to the expected cycle and last the pulse length.
	task automatic fire_in(input int base);
		time_fire(base + 10, n);
		check("fire time", {7'h0, n >= base - 2 && n <= base + 3}, 8'h01);
		n = 0;
		while (system_reset_out === 1'b1 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		check("pulse width", 8'(n), 8'(PULSE));
	endtask

	// Long enough for every test, minute units included, several times over.
	initial begin
		#100000;
		err_total++;
		wrap_up();
	end

	initial begin
		sys_clk = 1'b0;
		srst = 1'b1;
		pin_ext = 8'h00;
		err_total = 0;
		checks_done = 0;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		host.reg_rd(`IDX_ACTIVATE, rv);
		check("locked read", rv, 8'h00);
		host.open_device();
		host.reg_rd(`IDX_ACTIVATE, rv);
		check("activate reset", rv, `RST_ACTIVATE);
		host.reg_rd(`IDX_PORT_DIR, rv);
		check("direction reset", rv, `RST_PORT_DIR);
		host.reg_rd(`IDX_UNIT_SELECT, rv);
		check("unit reset", rv, `RST_UNIT);
		host.reg_rd(8'h55, rv);
		check("unmapped read", rv, 8'h00);
		$display("test reset_values done");
		// Port test: f2 leaves the watchdog off; the port works whatever the activate value.
		host.reg_wr(`IDX_ACTIVATE, 8'hf2);
		pin_ext <= 8'ha5;
		host.reg_wr(`IDX_PORT_DIR, 8'hff);
		// Pin outputs change on the edge that takes the write, so look half a cycle later.
		@(negedge sys_clk);
		check("all input oe", pin_oe, 8'h00);
		host.reg_rd(`IDX_PORT_DATA, rv);
		check("input read", rv, 8'ha5);
		host.reg_wr(`IDX_PORT_DIR, 8'h00);
		host.reg_wr(`IDX_PORT_DATA, 8'hff);
		@(negedge sys_clk);
		check("all output oe", pin_oe, 8'hff);
		check("output high", pin_out, 8'hff);
		host.reg_wr(`IDX_PORT_DATA, 8'h3c);
		@(negedge sys_clk);
		check("output pattern", pin_out, 8'h3c);
		host.reg_wr(`IDX_PORT_DIR, 8'h0f);
		@(negedge sys_clk);
		check("mixed oe", pin_oe, 8'hf0);
		host.reg_rd(`IDX_PORT_DATA, rv);
		check("mixed read", rv, 8'h35);
		$display("test port done");
		// Second units: three ticks then reset.
		host.reg_wr(`IDX_ACTIVATE, 8'h01);
		host.reg_wr(`IDX_UNIT_SELECT, 8'h00);
		host.reg_wr(`IDX_TIMEOUT_COUNT, 8'h03);
		fire_in(3 * TICK);
		host.reg_rd(`IDX_TIMEOUT_COUNT, rv);
		check("count after expiry", rv, 8'h00);
		$display("test seconds done");
		// A rewrite two ticks in must push the expiry out by the full count.
		host.reg_wr(`IDX_TIMEOUT_COUNT, 8'h03);
		repeat (2 * TICK) @(negedge sys_clk);
		host.reg_wr(`IDX_TIMEOUT_COUNT, 8'h03);
		fire_in(3 * TICK);
		$display("test restart done");
		// Stopping mid-count must keep reset away.
		host.reg_wr(`IDX_TIMEOUT_COUNT, 8'h02);
		host.reg_wr(`IDX_ACTIVATE, 8'h00);
		time_fire(6 * TICK, n);
		check("no fire when off", {7'h0, system_reset_out}, 8'h00);
		$display("test disable done");
		// Minute units: one count lasts sixty ticks.
		host.reg_wr(`IDX_UNIT_SELECT, 8'h08);
		host.reg_rd(`IDX_UNIT_SELECT, rv);
		check("unit minute", rv, 8'h08);
		host.reg_wr(`IDX_ACTIVATE, 8'h01);
		host.reg_wr(`IDX_TIMEOUT_COUNT, 8'h01);
		fire_in(`SECONDS_PER_MINUTE * TICK);
		$display("test minutes done");
		// The lock key must close the register space again.
		host.io_wr(1'b0, `CFG_LOCK_KEY);
		host.reg_rd(`IDX_UNIT_SELECT, rv);
		check("relocked read", rv, 8'h00);
		$display("test relock done");
		wrap_up();
	end
endmodule // testbench
